// ### hw/dmc_pkg.sv
package dmc_pkg;

    // wishbone register offsets
    localparam logic [3:0] DMC_OFF_SW1    = 4'h0;
    localparam logic [3:0] DMC_OFF_SW2    = 4'h4;
    localparam logic [3:0] DMC_OFF_CTRL   = 4'h8;
    localparam logic [3:0] DMC_OFF_STATUS = 4'hC;

    // first bank bit positions
    localparam int DMC_S1_HOTLINE  = 0;
    localparam int DMC_S1_FTR      = 1;
    localparam int DMC_S1_DUPLEX   = 2;
    localparam int DMC_S1_SYNC     = 3;
    localparam int DMC_S1_INTCLK   = 4;
    localparam int DMC_S1_NETWORK  = 5;
    localparam int DMC_S1_AUTOANS  = 6;
    localparam int DMC_S1_LOOPBACK = 7;
    // second bank bit positions
    localparam int DMC_S2_ALTNET   = 0;
    localparam int DMC_S2_HOST     = 1;
    localparam int DMC_S2_SDS      = 2;
    localparam int DMC_S2_ECD      = 3;
    localparam logic [7:0] DMC_S2_USED_MASK = 8'h0F;

    // reset values
    localparam logic [7:0] DMC_SW1_RST  = 8'h00;
    localparam logic [7:0] DMC_SW2_RST  = 8'h00;
    localparam logic [3:0] DMC_RATE_RST = 4'h0;
    localparam logic       DMC_V35_RST  = 1'b0;

    // rate codes (async and sync share the field)
    localparam logic [3:0] DMC_RATE_110 = 4'h0;
    localparam logic [3:0] DMC_RATE_56K = 4'hA;
    localparam logic [3:0] DMC_RATE_64K = 4'hB;

    // ascii carriage return
    localparam logic [7:0] DMC_CHAR_CR = 8'h0D;

    // timing
    localparam longint DMC_CLK_HZ      = 100_000_000;
    localparam int     DMC_REDIAL_MS   = 1500;
    localparam int     DMC_ATTEMPT_MS  = 40000;
    localparam longint DMC_REDIAL_CYC  = DMC_CLK_HZ * DMC_REDIAL_MS / 1000;
    localparam longint DMC_ATTEMPT_CYC = DMC_CLK_HZ * DMC_ATTEMPT_MS / 1000;
    localparam int     DMC_TMR_W       = 32;
    localparam int     DMC_TXCLK_DIV   = 8;

    // call state
    typedef enum logic [2:0] {
        DMC_IDLE    = 3'b000,
        DMC_DIALING = 3'b001,
        DMC_CONN    = 3'b011,
        DMC_WAIT    = 3'b010,
        DMC_RING    = 3'b110
    } dmc_state_t;

    // wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } dmc_wb_req_t;

    // derived line configuration
    typedef struct packed {
        logic full_duplex;
        logic two_stop;
        logic prompts_on;
        logic kbd_allowed;
        logic ecd_engaged;
        logic sds_latched;
    } dmc_cfg_t;

endpackage

// ### hw/dmc_call_ctrl.sv
`timescale 1ns/1ps
module dmc_call_ctrl
    import dmc_pkg::*;
#(
    parameter longint REDIAL_CYC  = DMC_REDIAL_CYC,
    parameter longint ATTEMPT_CYC = DMC_ATTEMPT_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire dmc_wb_req_t wb_req_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // terminal side
    input  wire logic        term_ready_i,
    input  wire logic        rx_char_valid_i,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        ext_tx_clk_i,
    output logic             tx_clk_o,
    output logic             rx_clk_o,
    output logic             echo_valid_o,
    output logic [7:0]       echo_char_o,
    // front panel
    input  wire logic        data_line_key_i,
    input  wire logic        kbd_dial_start_i,
    input  wire logic        kbd_dial_end_i,
    output logic             v35_led_o,
    // network side
    input  wire logic        incoming_i,
    input  wire logic        connected_i,
    input  wire logic        disconnected_i,
    output logic             dial_o,
    output logic             answer_o,
    output logic             abort_o,
    output logic             remote_loop_o,
    output logic             net_clk_sync_o,
    output dmc_cfg_t         cfg_o
);

    // register state
    logic [7:0]  sw1_r, sw1_nxt;
    logic [7:0]  sw2_r, sw2_nxt;
    logic [3:0]  rate_r, rate_nxt;
    logic        v35_r, v35_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    // call state
    dmc_state_t            st_r, st_nxt;
    logic [DMC_TMR_W-1:0]  tmr_r, tmr_nxt;
    logic                  dtr_d_r, dtr_d_nxt;
    logic                  kbd_r, kbd_nxt;
    logic                  sds_r, sds_nxt;
    logic                  ecd_r, ecd_nxt;
    logic                  rej_r, rej_nxt;
    // outputs
    logic       dial_r, dial_nxt, ans_r, ans_nxt, abort_r, abort_nxt;
    logic       echo_v_r, echo_v_nxt;
    logic [7:0] echo_c_r, echo_c_nxt;
    logic [2:0] div_r, div_nxt;
    logic       txc_r, txc_nxt, rxc_r, rxc_nxt;
    dmc_cfg_t   cfg_r, cfg_nxt;

    // derived settings
    logic dtr_eff, virtual_leased_line, sync_m, high_rate, ans_req, call_ok, wb_hit;
    always_comb begin
        dtr_eff   = term_ready_i | sw1_r[DMC_S1_FTR];
        virtual_leased_line       = sw1_r[DMC_S1_HOTLINE] & sw1_r[DMC_S1_FTR];
        sync_m    = sw1_r[DMC_S1_SYNC];
        high_rate = (rate_r == DMC_RATE_56K) | (rate_r == DMC_RATE_64K);
        // sds only accepts sync 56/64 calls
        call_ok   = ~sds_r | (sync_m & high_rate);
        ans_req   = sw1_r[DMC_S1_AUTOANS] | data_line_key_i
                    | (~sync_m & rx_char_valid_i & (rx_char_i == DMC_CHAR_CR));
        wb_hit    = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
    end

    // wishbone slave, one wait-free ack after request
    always_comb begin
        sw1_nxt  = sw1_r;
        sw2_nxt  = sw2_r;
        rate_nxt = rate_r;
        v35_nxt  = v35_r;
        ack_nxt  = wb_hit;
        dat_nxt  = 32'h0000_0000;
        if (wb_hit) begin
            if (wb_req_i.adr == DMC_OFF_SW1) begin
                if (wb_req_i.we && wb_req_i.sel[0]) sw1_nxt = wb_req_i.dat[7:0];
                dat_nxt = {24'h000000, sw1_r};
            end else if (wb_req_i.adr == DMC_OFF_SW2) begin
                // reserved positions ignored
                if (wb_req_i.we && wb_req_i.sel[0])
                    sw2_nxt = wb_req_i.dat[7:0] & DMC_S2_USED_MASK;
                dat_nxt = {24'h000000, sw2_r};
            end else if (wb_req_i.adr == DMC_OFF_CTRL) begin
                if (wb_req_i.we && wb_req_i.sel[0]) begin
                    rate_nxt = wb_req_i.dat[3:0];
                    v35_nxt  = wb_req_i.dat[4];
                end
                dat_nxt = {27'h0000000, v35_r, rate_r};
            end else if (wb_req_i.adr == DMC_OFF_STATUS) begin
                dat_nxt = {22'h000000, rej_r, ecd_r, sds_r, kbd_r, dtr_eff, virtual_leased_line,
                           1'b0, st_r};
            end
        end
    end

    // call control state machine
    always_comb begin
        st_nxt     = st_r;
        tmr_nxt    = tmr_r;
        dtr_d_nxt  = dtr_eff;
        dial_nxt   = 1'b0;
        ans_nxt    = 1'b0;
        abort_nxt  = 1'b0;
        sds_nxt    = sds_r;
        ecd_nxt    = ecd_r;
        if (data_line_key_i) begin
            // switched service settings latched at key press
            sds_nxt = sw2_r[DMC_S2_SDS];
            ecd_nxt = sw2_r[DMC_S2_ECD] & sw2_r[DMC_S2_SDS];
        end
        case (st_r)
            DMC_IDLE: begin
                if (incoming_i && dtr_eff && call_ok) begin
                    st_nxt = DMC_RING;
                end else if (sw1_r[DMC_S1_HOTLINE] && dtr_eff && !dtr_d_r
                             && call_ok) begin
                    dial_nxt = 1'b1;
                    tmr_nxt  = '0;
                    st_nxt   = DMC_DIALING;
                end
            end
            DMC_RING: begin
                if (!incoming_i) begin
                    st_nxt = DMC_IDLE;
                end else if (ans_req) begin
                    ans_nxt = 1'b1;
                    tmr_nxt = '0;
                    st_nxt  = DMC_DIALING;
                end
            end
            DMC_DIALING: begin
                tmr_nxt = tmr_r + 1'b1;
                if (connected_i) begin
                    st_nxt = DMC_CONN;
                end else if (virtual_leased_line && tmr_r >= DMC_TMR_W'(ATTEMPT_CYC - 1)) begin
                    abort_nxt = 1'b1;
                    tmr_nxt   = '0;
                    st_nxt    = DMC_WAIT;
                end else if (disconnected_i) begin
                    tmr_nxt = '0;
                    st_nxt  = virtual_leased_line ? DMC_WAIT : DMC_IDLE;
                end
            end
            DMC_CONN: begin
                if (disconnected_i) begin
                    tmr_nxt = '0;
                    st_nxt  = virtual_leased_line ? DMC_WAIT : DMC_IDLE;
                end
            end
            DMC_WAIT: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r >= DMC_TMR_W'(REDIAL_CYC - 1)) begin
                    dial_nxt = 1'b1;
                    tmr_nxt  = '0;
                    st_nxt   = DMC_DIALING;
                end
            end
            default: st_nxt = DMC_IDLE;
        endcase
        // leaving virtual leased line stops redial
        if (!virtual_leased_line && (st_r == DMC_WAIT)) begin
            st_nxt   = DMC_IDLE;
            dial_nxt = 1'b0;
        end
    end

    // keyboard dialing and echo
    always_comb begin
        kbd_nxt    = kbd_r;
        rej_nxt    = rej_r;
        echo_v_nxt = 1'b0;
        echo_c_nxt = echo_c_r;
        if (kbd_dial_start_i) begin
            // async only; sync mode is keypad only
            kbd_nxt = ~sync_m;
            rej_nxt = sync_m;
        end
        if (kbd_dial_end_i || st_r == DMC_CONN) kbd_nxt = 1'b0;
        if (kbd_r && rx_char_valid_i) begin
            echo_v_nxt = 1'b1;
            echo_c_nxt = rx_char_i;
        end
    end

    // clocks and derived configuration
    always_comb begin
        div_nxt = div_r + 3'd1;
        rxc_nxt = (div_r == 3'(DMC_TXCLK_DIV - 1)) ? ~rxc_r : rxc_r;
        // transmit clock from terminal or internal divider
        txc_nxt = sw1_r[DMC_S1_INTCLK] ? rxc_nxt : ext_tx_clk_i;
        cfg_nxt.full_duplex = ~sw1_r[DMC_S1_DUPLEX]
                              | ~(sync_m & sw2_r[DMC_S2_ALTNET])
                              | (sync_m & high_rate);
        cfg_nxt.two_stop    = ~sync_m & (rate_r == DMC_RATE_110);
        cfg_nxt.prompts_on  = sync_m | ~sw2_r[DMC_S2_HOST];
        cfg_nxt.kbd_allowed = ~sync_m;
        cfg_nxt.ecd_engaged = ecd_r & sds_r;
        cfg_nxt.sds_latched = sds_r;
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw1_r    <= DMC_SW1_RST;
            sw2_r    <= DMC_SW2_RST;
            rate_r   <= DMC_RATE_RST;
            v35_r    <= DMC_V35_RST;
            ack_r    <= 1'b0;
            dat_r    <= 32'h0000_0000;
            st_r     <= DMC_IDLE;
            tmr_r    <= '0;
            dtr_d_r  <= 1'b0;
            kbd_r    <= 1'b0;
            sds_r    <= 1'b0;
            ecd_r    <= 1'b0;
            rej_r    <= 1'b0;
            dial_r   <= 1'b0;
            ans_r    <= 1'b0;
            abort_r  <= 1'b0;
            echo_v_r <= 1'b0;
            echo_c_r <= 8'h00;
            div_r    <= 3'd0;
            txc_r    <= 1'b0;
            rxc_r    <= 1'b0;
            cfg_r    <= '0;
        end else begin
            sw1_r    <= sw1_nxt;
            sw2_r    <= sw2_nxt;
            rate_r   <= rate_nxt;
            v35_r    <= v35_nxt;
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
            st_r     <= st_nxt;
            tmr_r    <= tmr_nxt;
            dtr_d_r  <= dtr_d_nxt;
            kbd_r    <= kbd_nxt;
            sds_r    <= sds_nxt;
            ecd_r    <= ecd_nxt;
            rej_r    <= rej_nxt;
            dial_r   <= dial_nxt;
            ans_r    <= ans_nxt;
            abort_r  <= abort_nxt;
            echo_v_r <= echo_v_nxt;
            echo_c_r <= echo_c_nxt;
            div_r    <= div_nxt;
            txc_r    <= txc_nxt;
            rxc_r    <= rxc_nxt;
            cfg_r    <= cfg_nxt;
        end
    end

    // flop outputs
    assign wb_dat_o       = dat_r;
    assign wb_ack_o       = ack_r;
    assign dial_o         = dial_r;
    assign answer_o       = ans_r;
    assign abort_o        = abort_r;
    assign echo_valid_o   = echo_v_r;
    assign echo_char_o    = echo_c_r;
    assign tx_clk_o       = txc_r;
    assign rx_clk_o       = rxc_r;
    assign v35_led_o      = v35_r;
    assign remote_loop_o  = sw1_r[DMC_S1_LOOPBACK];
    assign net_clk_sync_o = sw1_r[DMC_S1_NETWORK];
    assign cfg_o          = cfg_r;

endmodule

// ### dv/dmc_net_model.sv
`timescale 1ns/1ps
module dmc_net_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // requests from the data module
    input  wire logic       dial_i,
    input  wire logic       answer_i,
    input  wire logic       abort_i,
    // scenario control
    input  wire logic       hang_i,
    input  wire logic [7:0] delay_i,
    // line events
    output logic            connected_o,
    output logic            disconnected_o
);
    logic [7:0] cnt_r, cnt_nxt;
    logic       con_r, con_nxt, dis_nxt;
    // setup countdown, a zero delay never connects
    always_comb begin
        cnt_nxt = (cnt_r > 8'h01) ? cnt_r - 8'h01 : 8'h00;
        con_nxt = con_r || (cnt_r == 8'h01);
        dis_nxt = con_r && hang_i;
        if (dial_i || answer_i) cnt_nxt = delay_i;
        if (abort_i) cnt_nxt = 8'h00;
        if (dis_nxt) con_nxt = 1'b0;
    end
    // registered line state
    always_ff @(posedge clk_i) begin
        cnt_r          <= rst_i ? 8'h00 : cnt_nxt;
        con_r          <= rst_i ? 1'b0 : con_nxt;
        disconnected_o <= rst_i ? 1'b0 : dis_nxt;
    end
    assign connected_o = con_r;
endmodule

// ### dv/dmc_call_ctrl_assertions.sv
`timescale 1ns/1ps
module dmc_chk
    import dmc_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire dmc_wb_req_t wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // terminal and panel
    input wire logic        rx_char_valid_i,
    input wire logic [7:0]  rx_char_i,
    input wire logic        rx_clk_o,
    input wire logic        echo_valid_o,
    input wire logic [7:0]  echo_char_o,
    input wire logic        v35_led_o,
    // network
    input wire logic        connected_i,
    input wire logic        dial_o,
    input wire logic        answer_o,
    input wire logic        abort_o,
    input wire logic        remote_loop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       req, wr, rxp_r;
    logic [5:0] run_r, run_nxt;
    // new request and lane-0 write
    assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    assign wr  = req && wb_req_i.we && wb_req_i.sel[0];
    // cycles since the receive clock last moved
    always_comb run_nxt = (rx_clk_o != rxp_r) ? 6'h00 : run_r + 6'h01;
    always_ff @(posedge clk_i) begin
        rxp_r <= rx_clk_o;
        run_r <= rst_i ? 6'h00 : run_nxt;
    end
    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_unmapped_zero: assert property (req && wb_req_i.adr[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_led_ctrl: assert property (
        wr && wb_req_i.adr == DMC_OFF_CTRL |-> ##2 v35_led_o == $past(wb_req_i.dat[4], 2))
        else $error("indicator not following control");
    a_loop_sw1: assert property (
        wr && wb_req_i.adr == DMC_OFF_SW1 |-> ##2 remote_loop_o == $past(wb_req_i.dat[7], 2))
        else $error("loopback not following bank one");
    a_echo_char: assert property (
        echo_valid_o |-> $past(rx_char_valid_i) && echo_char_o == $past(rx_char_i))
        else $error("echo without matching character");
    a_rx_clk_runs: assert property (run_r < 6'h10)
        else $error("receive clock stopped");
    a_strobe_pulse: assert property (
        dial_o || answer_o || abort_o |=> !(dial_o || answer_o || abort_o))
        else $error("call strobe longer than one cycle");
    a_abort_unconn: assert property (abort_o |-> !$past(connected_i))
        else $error("abort while connected");
    c_dial: cover property (dial_o);
    c_abort: cover property (abort_o);
    c_answer: cover property (answer_o);
    c_echo: cover property (echo_valid_o);
endmodule

bind dmc_call_ctrl dmc_chk u_chk (.*);

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import dmc_pkg::*;
;
    typedef struct packed {
        logic [3:0] adr;
        logic [3:0] sel;
        logic       we;
        logic [7:0] d;
        logic [7:0] q;
    } dmc_row_t;
    localparam int RED = 20;
    localparam int ATT = 50;
    localparam dmc_row_t ROWS [9] = '{
        '{DMC_OFF_SW1, 4'hF, 1'b0, 8'h00, 8'h00}, '{DMC_OFF_SW2, 4'hF, 1'b0, 8'h00, 8'h00},
        '{DMC_OFF_CTRL, 4'hF, 1'b0, 8'h00, 8'h00}, '{DMC_OFF_SW1, 4'hF, 1'b1, 8'hA5, 8'hA5},
        '{DMC_OFF_SW2, 4'hF, 1'b1, 8'hFF, 8'h0F}, '{DMC_OFF_CTRL, 4'hF, 1'b1, 8'h1B, 8'h1B},
        '{DMC_OFF_SW1, 4'hE, 1'b1, 8'h5A, 8'hA5}, '{4'h2, 4'hF, 1'b1, 8'h5A, 8'h00},
        '{DMC_OFF_SW1, 4'hF, 1'b1, 8'h00, 8'h00}};
    logic        clk_i = 1'b0, rst_i = 1'b1, ready = 1'b0, extc = 1'b0;
    logic [5:0]  p = '0;
    logic [7:0]  rxc = 8'h00, dly = 8'h03, echo_char_o;
    logic [31:0] rd, wb_dat_o;
    logic [3:0]  ev;
    logic        wb_ack_o, tx_clk_o, echo_valid_o, dial_o, answer_o, abort_o, conn, disc, ncs;
    dmc_wb_req_t req = '0;
    dmc_cfg_t    cfg;
    int          fails = 0, samples_checked = 0, cycles = 0, n, tg;
    assign ev = {echo_valid_o, abort_o, answer_o, dial_o};
    dmc_call_ctrl #(.REDIAL_CYC(RED), .ATTEMPT_CYC(ATT)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .term_ready_i(ready), .rx_char_valid_i(p[0]), .rx_char_i(rxc), .ext_tx_clk_i(extc),
        .tx_clk_o(tx_clk_o), .rx_clk_o(), .echo_valid_o(echo_valid_o), .echo_char_o(echo_char_o),
        .data_line_key_i(p[1]), .kbd_dial_start_i(p[2]), .kbd_dial_end_i(p[3]), .v35_led_o(),
        .incoming_i(p[4]), .connected_i(conn), .disconnected_i(disc), .dial_o(dial_o),
        .answer_o(answer_o), .abort_o(abort_o), .remote_loop_o(), .net_clk_sync_o(ncs), .cfg_o(cfg));
    dmc_net_model NET (.clk_i(clk_i), .rst_i(rst_i), .dial_i(dial_o), .answer_i(answer_o),
        .abort_i(abort_o), .hang_i(p[5]), .delay_i(dly), .connected_o(conn),
        .disconnected_o(disc));
    // clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic [3:0] a, input logic [3:0] s, input logic w,
                      input logic [7:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, s, a, {24'h0, d}};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        req <= '0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(a, 4'hF, 1'b1, d);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        p[k] <= 1'b1;
        @(posedge clk_i);
        p[k] <= 1'b0;
    endtask
    // cycles until event k, or -1
    task automatic wait_ev(input int k, input int lim);
        n = -1;
        for (int i = 1; i <= lim && n < 0; i++) begin
            @(posedge clk_i);
            if (ev[k] === 1'b1) n = i;
        end
    endtask
    initial begin
        repeat (19) @(posedge clk_i);
        chk({dial_o, answer_o, abort_o, echo_valid_o, wb_ack_o}, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].we) wb(ROWS[i].adr, ROWS[i].sel, 1'b1, ROWS[i].d);
            wb(ROWS[i].adr, 4'hF, 1'b0, 8'h00);
            chk(rd, {24'h0, ROWS[i].q});
        end
        // rows left bank two at 0F and rate at 64k; restore plain async 110
        wr(DMC_OFF_SW2, 8'h00);
        wr(DMC_OFF_CTRL, {4'h0, DMC_RATE_110});
        wr(DMC_OFF_SW1, 8'h00);
        chk(cfg, 6'h3C);
        wr(DMC_OFF_CTRL, {4'h0, DMC_RATE_56K});
        chk(cfg.two_stop, 1'b0);
        wr(DMC_OFF_SW2, 8'h01);
        wr(DMC_OFF_SW1, 8'h0C);
        wr(DMC_OFF_CTRL, {4'h0, DMC_RATE_64K});
        chk(cfg.full_duplex, 1'b1);
        wr(DMC_OFF_CTRL, {4'h0, DMC_RATE_110});
        chk({cfg.full_duplex, cfg.kbd_allowed}, 2'b00);
        wr(DMC_OFF_SW1, 8'h00);
        wr(DMC_OFF_SW2, 8'h02);
        chk(cfg.prompts_on, 1'b0);
        // keyboard dialing, refused in sync then echoed in async
        wr(DMC_OFF_SW2, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr(DMC_OFF_SW1, m == 0 ? 8'h08 : 8'h00);
            if (m < 2) pulse(2);
            rxc <= 8'h41 + m[7:0];
            pulse(0);
            wait_ev(3, 6);
            chk(n > 0 ? echo_char_o : 8'h00, m == 1 ? 8'h42 : 8'h00);
            if (m == 0) wb(DMC_OFF_STATUS, 4'hF, 1'b0, 8'h00);
            if (m == 0) chk(rd[9], 1'b1);
            pulse(3);
            repeat (6) @(posedge clk_i);
            pulse(5);
        end
        // answer: auto, manual by return, return refused in sync then key
        ready <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(DMC_OFF_SW1, c == 0 ? 8'h40 : (c == 1 ? 8'h00 : 8'h08));
            // ringing is a level, held until the answer is seen
            @(posedge clk_i);
            p[4] <= 1'b1;
            rxc <= DMC_CHAR_CR;
            if (c > 0) pulse(0);
            wait_ev(1, 8);
            chk(n > 0, c < 2);
            if (c == 2) pulse(1);
            if (c == 2) wait_ev(1, 8);
            chk(n > 0, 1'b1);
            p[4] <= 1'b0;
            repeat (6) @(posedge clk_i);
            pulse(5);
        end
        // forced ready with the terminal silent
        ready <= 1'b0;
        wr(DMC_OFF_SW1, 8'h40);
        wb(DMC_OFF_STATUS, 4'hF, 1'b0, 8'h00);
        chk(rd[5], 1'b0);
        wr(DMC_OFF_SW1, 8'h42);
        wb(DMC_OFF_STATUS, 4'hF, 1'b0, 8'h00);
        chk(rd[5], 1'b1);
        @(posedge clk_i);
        p[4] <= 1'b1;
        wait_ev(1, 8);
        chk(n > 0, 1'b1);
        p[4] <= 1'b0;
        repeat (6) @(posedge clk_i);
        pulse(5);
        // hotline dial, no redial without forced ready
        wr(DMC_OFF_SW1, 8'h01);
        for (int h = 0; h < 2; h++) begin
            ready <= 1'b1;
            wait_ev(0, 5);
            chk(n > 0, 1'b1);
            repeat (6) @(posedge clk_i);
            if (h == 1) wr(DMC_OFF_SW1, 8'h03);
            // redials after this never connect
            if (h == 1) dly <= 8'h00;
            pulse(5);
            wait_ev(0, h == 0 ? 40 : RED + 10);
            tg = n;
            chk(h == 0 ? tg < 0 : tg >= RED - 1 && tg <= RED + 4, 1'b1);
            ready <= 1'b0;
            @(posedge clk_i);
        end
        wait_ev(2, ATT + 10);
        chk(n >= ATT - 2 && n <= ATT + 4, 1'b1);
        wait_ev(0, RED + 10);
        chk(n >= RED - 2 && n <= RED + 4, 1'b1);
        wr(DMC_OFF_SW1, 8'h01);
        wait_ev(0, 120);
        chk(n, -1);
        wr(DMC_OFF_SW1, 8'h20);
        chk(ncs, 1'b1);
        // transmit clock from terminal, then internal
        extc <= 1'b1;
        wr(DMC_OFF_SW1, 8'h00);
        chk(tx_clk_o, 1'b1);
        extc <= 1'b0;
        wr(DMC_OFF_SW1, 8'h10);
        tg = 0;
        for (int t = 0; t < 40; t++) begin
            @(posedge clk_i);
            tg += (tx_clk_o === 1'b1);
        end
        chk(tg > 0 && tg < 40, 1'b1);
        // switched service and canceller disabler latched at key
        wr(DMC_OFF_SW1, 8'h08);
        for (int e = 0; e < 2; e++) begin
            wr(DMC_OFF_SW2, e == 0 ? 8'h08 : 8'h0C);
            pulse(1);
            repeat (3) @(posedge clk_i);
            chk({cfg.sds_latched, cfg.ecd_engaged}, e == 0 ? 2'b00 : 2'b11);
        end
        give_verdict();
    end
endmodule
